// ---- pmbp_pkg.sv ----
/*
 * Constants, types and field layout for the program memory block
 * protection logic.
 * Assumes a single core clock and 22-bit program space addresses.
 */
package pmbp_pkg;

  // ***********************************************************
  // address map
  // ***********************************************************
  localparam logic [21:0] PMBP_BOOT_END_SMALL = 22'h0007FF;
  localparam logic [21:0] PMBP_BOOT_END_LARGE = 22'h000FFF;
  localparam logic [21:0] PMBP_BLK0_START = 22'h001000;
  localparam logic [21:0] PMBP_BLK0_END = 22'h001FFF;
  localparam logic [21:0] PMBP_BLK1_START = 22'h002000;
  localparam logic [21:0] PMBP_BLK1_END = 22'h003FFF;
  localparam logic [21:0] PMBP_ID_START = 22'h200000;
  localparam logic [21:0] PMBP_ID_END = 22'h200007;
  localparam logic [21:0] PMBP_DEVID_LO = 22'h3FFFFE;
  localparam logic [21:0] PMBP_DEVID_HI = 22'h3FFFFF;
  localparam logic [21:0] PMBP_CFG_START = 22'h300000;
  localparam logic [21:0] PMBP_CFG_END = 22'h30000D;

  // ***********************************************************
  // protection register offsets
  // ***********************************************************
  localparam logic [21:0] PMBP_BLOCK_CODE_PROTECT_LOW = 22'h300008;
  localparam logic [21:0] PMBP_BOOT_CODE_PROTECT_HIGH = 22'h300009;
  localparam logic [21:0] PMBP_BLOCK_WRITE_PROTECT_LOW = 22'h30000A;
  localparam logic [21:0] PMBP_BOOT_CONFIG_WRITE_PROTECT_HIGH = 22'h30000B;
  localparam logic [21:0] PMBP_BLOCK_TABLE_READ_PROTECT_LOW = 22'h30000C;
  localparam logic [21:0] PMBP_BOOT_TABLE_READ_PROTECT_HIGH = 22'h30000D;

  // ***********************************************************
  // field positions and reset values
  // ***********************************************************
  localparam int PMBP_BLK0_BIT = 0;
  localparam int PMBP_BLK1_BIT = 1;
  localparam int PMBP_BOOT_BIT = 6;
  localparam int PMBP_CFGWP_BIT = 5;
  localparam logic [7:0] PMBP_CFG_RESET = 8'hFF;
  localparam logic [7:0] PMBP_ID_RESET = 8'hFF;
  localparam logic [7:0] PMBP_DEVID_LO_VAL = 8'h5A; // arbitrary
  localparam logic [7:0] PMBP_DEVID_HI_VAL = 8'hA5; // arbitrary
  localparam int PMBP_NUM_REGIONS = 3;
  localparam int PMBP_NUM_ID = 8;
  localparam int PMBP_NUM_CFG = 14;

  // ***********************************************************
  // types
  // ***********************************************************
  typedef enum logic [1:0] {
    PMBP_REG_BOOT,
    PMBP_REG_BLK0,
    PMBP_REG_BLK1,
    PMBP_REG_NONE
  } pmbp_region_t;

  typedef struct packed {
    logic code_protect;
    logic write_protect;
    logic external_read_protect;
  } pmbp_region_bits_t;

  // access request from core or programmer
  typedef struct packed {
    logic valid;
    logic write;
    logic [21:0] addr;
    logic [7:0] wdata;
  } pmbp_req_t;

  // programmer erase command
  typedef enum logic [2:0] {
    PMBP_ERASE_NONE,
    PMBP_ERASE_CHIP,
    PMBP_ERASE_BOOT,
    PMBP_ERASE_BLK0,
    PMBP_ERASE_BLK1
  } pmbp_erase_t;

endpackage

// ---- pmbp_region_decode.sv ----
/*
 * Decodes a program address to its protection region.
 * Assumes the boot size strap is steady while in use.
 */
module pmbp_region_decode
  import pmbp_pkg::*;
(
  input wire logic [21:0] addr_in,
  input wire logic boot_large_in,
  output pmbp_region_t region_out
);

  // ***********************************************************
  // region compare
  // ***********************************************************
  logic [21:0] boot_end;
  assign boot_end = boot_large_in ? PMBP_BOOT_END_LARGE
                                  : PMBP_BOOT_END_SMALL;

  // boot from zero, block 0 and block 1 at fixed bounds
  always_comb begin
    if (addr_in <= boot_end) begin
      region_out = PMBP_REG_BOOT;
    end else if (addr_in >= PMBP_BLK0_START &&
                 addr_in <= PMBP_BLK0_END) begin
      region_out = PMBP_REG_BLK0;
    end else if (addr_in >= PMBP_BLK1_START &&
                 addr_in <= PMBP_BLK1_END) begin
      region_out = PMBP_REG_BLK1;
    end else begin
      region_out = PMBP_REG_NONE;
    end
  end

endmodule // pmbp_region_decode

// ---- pmbp_region_select.sv ----
/*
 * Picks the protection bits of one region.
 * Assumes a region code from the region decoder.
 */
module pmbp_region_select
  import pmbp_pkg::*;
(
  input wire pmbp_region_t region_in,
  input wire pmbp_region_bits_t [PMBP_NUM_REGIONS-1:0] bits_in,
  output pmbp_region_bits_t sel_out,
  output logic in_region_out
);

  // ***********************************************************
  // select; address outside every region reads back as all ones
  // ***********************************************************
  always_comb begin
    in_region_out = 1'b1;
    case (region_in)
      PMBP_REG_BOOT: sel_out = bits_in[0];
      PMBP_REG_BLK0: sel_out = bits_in[1];
      PMBP_REG_BLK1: sel_out = bits_in[2];
      default: begin
        sel_out = '{1'b1, 1'b1, 1'b1};
        in_region_out = 1'b0;
      end
    endcase
  end

endmodule // pmbp_region_select

// ---- pmbp_top.sv ----
/*
 * Program memory block protection: holds protection bits, user ID
 * bytes and device ID, and judges core table and programmer accesses.
 * Assumes one request per port per cycle and an external flash array
 * that performs permitted accesses; read data is returned one cycle
 * after the request.
 */
module pmbp_top
  import pmbp_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic boot_large_in,
  input wire pmbp_req_t core_req_in,
  input wire logic [21:0] core_fetch_addr_in,
  input wire pmbp_req_t prog_req_in,
  input wire pmbp_erase_t prog_erase_in,
  input wire logic [7:0] flash_rdata_in,
  output logic flash_access_out,
  output logic flash_write_out,
  output logic [21:0] flash_addr_out,
  output logic [7:0] flash_wdata_out,
  output logic core_rvalid_out,
  output logic [7:0] core_rdata_out,
  output logic core_refused_out,
  output logic prog_rvalid_out,
  output logic [7:0] prog_rdata_out,
  output logic prog_refused_out,
  output logic [PMBP_NUM_REGIONS-1:0] region_erase_out
);

  // ***********************************************************
  // state
  // ***********************************************************
  pmbp_region_bits_t [PMBP_NUM_REGIONS-1:0] region_bits;
  logic config_write_protect;
  logic [7:0] id_mem [PMBP_NUM_ID];

  // ***********************************************************
  // region decode of core target, core fetch and programmer
  // ***********************************************************
  pmbp_region_t core_region;
  pmbp_region_t fetch_region;
  pmbp_region_t prog_region;
  pmbp_region_bits_t core_bits;
  pmbp_region_bits_t prog_bits;
  logic core_in_region;
  logic prog_in_region;

  pmbp_region_decode u_dec_core (
    .addr_in(core_req_in.addr),
    .boot_large_in(boot_large_in),
    .region_out(core_region)
  );

  pmbp_region_decode u_dec_fetch (
    .addr_in(core_fetch_addr_in),
    .boot_large_in(boot_large_in),
    .region_out(fetch_region)
  );

  pmbp_region_decode u_dec_prog (
    .addr_in(prog_req_in.addr),
    .boot_large_in(boot_large_in),
    .region_out(prog_region)
  );

  pmbp_region_select u_sel_core (
    .region_in(core_region),
    .bits_in(region_bits),
    .sel_out(core_bits),
    .in_region_out(core_in_region)
  );

  pmbp_region_select u_sel_prog (
    .region_in(prog_region),
    .bits_in(region_bits),
    .sel_out(prog_bits),
    .in_region_out(prog_in_region)
  );

  // ***********************************************************
  // address class helpers
  // ***********************************************************
  function automatic logic is_id(input logic [21:0] a);
    is_id = (a >= PMBP_ID_START) && (a <= PMBP_ID_END);
  endfunction

  function automatic logic is_cfg(input logic [21:0] a);
    is_cfg = (a >= PMBP_CFG_START) && (a <= PMBP_CFG_END);
  endfunction

  function automatic logic is_devid(input logic [21:0] a);
    is_devid = (a == PMBP_DEVID_LO) || (a == PMBP_DEVID_HI);
  endfunction

  // read view of a configuration byte; unused bits read as zero
  function automatic logic [7:0] cfg_view(
    input logic [21:0] a,
    input pmbp_region_bits_t [PMBP_NUM_REGIONS-1:0] rb,
    input logic cwp
  );
    logic [7:0] v;
    v = 8'h00;
    case (a)
      PMBP_BLOCK_CODE_PROTECT_LOW: begin
        v[PMBP_BLK0_BIT] = rb[1].code_protect;
        v[PMBP_BLK1_BIT] = rb[2].code_protect;
      end
      PMBP_BOOT_CODE_PROTECT_HIGH:
        v[PMBP_BOOT_BIT] = rb[0].code_protect;
      PMBP_BLOCK_WRITE_PROTECT_LOW: begin
        v[PMBP_BLK0_BIT] = rb[1].write_protect;
        v[PMBP_BLK1_BIT] = rb[2].write_protect;
      end
      PMBP_BOOT_CONFIG_WRITE_PROTECT_HIGH: begin
        v[PMBP_BOOT_BIT] = rb[0].write_protect;
        v[PMBP_CFGWP_BIT] = cwp;
      end
      PMBP_BLOCK_TABLE_READ_PROTECT_LOW: begin
        v[PMBP_BLK0_BIT] = rb[1].external_read_protect;
        v[PMBP_BLK1_BIT] = rb[2].external_read_protect;
      end
      PMBP_BOOT_TABLE_READ_PROTECT_HIGH:
        v[PMBP_BOOT_BIT] = rb[0].external_read_protect;
      default: v = 8'h00;
    endcase
    cfg_view = v;
  endfunction

  // ***********************************************************
  // core access judgement
  // ***********************************************************
  logic core_flash_ok;
  logic core_zero_read;
  logic core_cfg_wr_ok;
  logic core_id_ok;

  // code-protect is not consulted for core accesses
  always_comb begin
    core_flash_ok = 1'b0;
    core_zero_read = 1'b0;
    core_cfg_wr_ok = 1'b0;
    core_id_ok = 1'b0;
    if (core_req_in.valid && !prog_req_in.valid) begin
      if (core_in_region) begin
        if (core_req_in.write) begin
          core_flash_ok = core_bits.write_protect;
        end else begin
          core_flash_ok = 1'b1;
          core_zero_read = !core_bits.external_read_protect &&
                           (fetch_region != core_region);
        end
      end else if (is_id(core_req_in.addr)) begin
        core_id_ok = 1'b1;
      end else if (is_cfg(core_req_in.addr)) begin
        core_cfg_wr_ok = core_req_in.write &&
                         config_write_protect;
      end
    end
  end

  // ***********************************************************
  // programmer access judgement
  // ***********************************************************
  logic prog_flash_ok;
  logic prog_cfg_wr;
  logic prog_id_ok;

  always_comb begin
    prog_flash_ok = 1'b0;
    prog_cfg_wr = 1'b0;
    prog_id_ok = 1'b0;
    if (prog_req_in.valid) begin
      if (prog_in_region) begin
        prog_flash_ok = prog_bits.code_protect;
      end else if (is_id(prog_req_in.addr)) begin
        prog_id_ok = 1'b1;
      end else if (is_cfg(prog_req_in.addr)) begin
        prog_cfg_wr = prog_req_in.write;
      end
    end
  end

  // ***********************************************************
  // flash array command (programmer has priority)
  // ***********************************************************
  always_comb begin
    flash_access_out = 1'b0;
    flash_write_out = 1'b0;
    flash_addr_out = core_req_in.addr;
    flash_wdata_out = core_req_in.wdata;
    if (clk_en_in && prog_flash_ok) begin
      flash_access_out = 1'b1;
      flash_write_out = prog_req_in.write;
      flash_addr_out = prog_req_in.addr;
      flash_wdata_out = prog_req_in.wdata;
    end else if (clk_en_in && core_flash_ok) begin
      flash_access_out = 1'b1;
      flash_write_out = core_req_in.write;
    end
  end

  // ***********************************************************
  // erase decode, only from the programmer port
  // ***********************************************************
  logic [PMBP_NUM_REGIONS-1:0] erase_hit;
  always_comb begin
    case (prog_erase_in)
      PMBP_ERASE_CHIP: erase_hit = 3'h7;
      PMBP_ERASE_BOOT: erase_hit = 3'h1;
      PMBP_ERASE_BLK0: erase_hit = 3'h2;
      PMBP_ERASE_BLK1: erase_hit = 3'h4;
      default: erase_hit = 3'h0;
    endcase
  end
  assign region_erase_out = clk_en_in ? erase_hit : 3'h0;

  // ***********************************************************
  // configuration byte writes: clear-only per bit
  // ***********************************************************
  logic cfg_wr;
  logic [21:0] cfg_wr_addr;
  logic [7:0] cfg_wr_data;
  assign cfg_wr = prog_cfg_wr || core_cfg_wr_ok;
  assign cfg_wr_addr = prog_cfg_wr ? prog_req_in.addr : core_req_in.addr;
  assign cfg_wr_data = prog_cfg_wr ? prog_req_in.wdata : core_req_in.wdata;

  // one protection slice per region
  genvar g;
  generate
    for (g = 0; g < PMBP_NUM_REGIONS; g++) begin : g_region
      localparam int BIT = (g == 0) ? PMBP_BOOT_BIT : (g - 1);
      localparam logic [21:0] CP_A = (g == 0) ?
        PMBP_BOOT_CODE_PROTECT_HIGH : PMBP_BLOCK_CODE_PROTECT_LOW;
      localparam logic [21:0] WP_A = (g == 0) ?
        PMBP_BOOT_CONFIG_WRITE_PROTECT_HIGH : PMBP_BLOCK_WRITE_PROTECT_LOW;
      localparam logic [21:0] RP_A = (g == 0) ?
        PMBP_BOOT_TABLE_READ_PROTECT_HIGH :
        PMBP_BLOCK_TABLE_READ_PROTECT_LOW;
      always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
          region_bits[g] <= '{1'b1, 1'b1, 1'b1};
        end else if (clk_en_in) begin
          if (erase_hit[g]) begin
            region_bits[g] <= '{1'b1, 1'b1, 1'b1};
          end else if (cfg_wr) begin
            // and-in written value: only 1 to 0 transitions
            if (cfg_wr_addr == CP_A && prog_cfg_wr) begin
              region_bits[g].code_protect <=
                region_bits[g].code_protect & cfg_wr_data[BIT];
            end
            if (cfg_wr_addr == WP_A) begin
              region_bits[g].write_protect <=
                region_bits[g].write_protect & cfg_wr_data[BIT];
            end
            if (cfg_wr_addr == RP_A) begin
              region_bits[g].external_read_protect <=
                region_bits[g].external_read_protect &
                cfg_wr_data[BIT];
            end
          end
        end
      end
    end
  endgenerate

  // configuration write-protect: programmer only, clear-only
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      config_write_protect <= 1'b1;
    end else if (clk_en_in) begin
      if (prog_erase_in == PMBP_ERASE_CHIP) begin
        config_write_protect <= 1'b1;
      end else if (prog_cfg_wr &&
                   prog_req_in.addr ==
                   PMBP_BOOT_CONFIG_WRITE_PROTECT_HIGH) begin
        config_write_protect <= config_write_protect &
                                prog_req_in.wdata[PMBP_CFGWP_BIT];
      end
    end
  end

  // ***********************************************************
  // user ID bytes
  // ***********************************************************
  logic id_wr;
  logic [2:0] id_idx;
  logic [7:0] id_wdata;
  assign id_wr = (prog_id_ok && prog_req_in.write) ||
                 (core_id_ok && core_req_in.write);
  assign id_idx = prog_id_ok ? prog_req_in.addr[2:0]
                             : core_req_in.addr[2:0];
  assign id_wdata = prog_id_ok ? prog_req_in.wdata : core_req_in.wdata;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < PMBP_NUM_ID; i++) begin
        id_mem[i] <= PMBP_ID_RESET;
      end
    end else if (clk_en_in) begin
      if (prog_erase_in == PMBP_ERASE_CHIP) begin
        for (int i = 0; i < PMBP_NUM_ID; i++) begin
          id_mem[i] <= PMBP_ID_RESET;
        end
      end else if (id_wr) begin
        id_mem[id_idx] <= id_wdata;
      end
    end
  end

  // ***********************************************************
  // read data staging: select captured at request, data next cycle
  // ***********************************************************
  typedef enum logic [2:0] {
    PMBP_SRC_FLASH,
    PMBP_SRC_ZERO,
    PMBP_SRC_ID,
    PMBP_SRC_CFG,
    PMBP_SRC_DEVID
  } pmbp_src_t;

  logic [7:0] core_local;
  pmbp_src_t core_src;
  always_comb begin
    core_src = PMBP_SRC_ZERO;
    core_local = 8'h00;
    if (core_flash_ok) begin
      core_src = core_zero_read ? PMBP_SRC_ZERO : PMBP_SRC_FLASH;
    end else if (core_id_ok) begin
      core_src = PMBP_SRC_ID;
      core_local = id_mem[core_req_in.addr[2:0]];
    end else if (is_cfg(core_req_in.addr)) begin
      core_src = PMBP_SRC_CFG;
      core_local = cfg_view(core_req_in.addr, region_bits,
                            config_write_protect);
    end else if (is_devid(core_req_in.addr)) begin
      core_src = PMBP_SRC_DEVID;
      core_local = (core_req_in.addr == PMBP_DEVID_LO) ?
                   PMBP_DEVID_LO_VAL : PMBP_DEVID_HI_VAL;
    end
  end

  logic core_rd_take;
  logic core_from_flash;
  logic [7:0] core_hold;
  assign core_rd_take = core_req_in.valid && !core_req_in.write &&
                        !prog_req_in.valid;

  // core read answer, and refusal flag for blocked writes
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      core_rvalid_out <= 1'b0;
      core_refused_out <= 1'b0;
      core_from_flash <= 1'b0;
      core_hold <= 8'h00;
    end else if (clk_en_in) begin
      core_rvalid_out <= core_rd_take;
      core_from_flash <= core_rd_take && core_src == PMBP_SRC_FLASH;
      core_hold <= core_local; // zero when read-protected
      core_refused_out <= core_req_in.valid && core_req_in.write &&
                          !prog_req_in.valid && !core_flash_ok &&
                          !core_id_ok && !core_cfg_wr_ok;
    end
  end
  assign core_rdata_out = core_from_flash ? flash_rdata_in : core_hold;

  logic prog_from_flash;
  logic [7:0] prog_hold;
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      prog_rvalid_out <= 1'b0;
      prog_refused_out <= 1'b0;
      prog_from_flash <= 1'b0;
      prog_hold <= 8'h00;
    end else if (clk_en_in) begin
      prog_rvalid_out <= prog_req_in.valid && !prog_req_in.write;
      prog_from_flash <= prog_flash_ok && !prog_req_in.write;
      prog_hold <= prog_id_ok ? id_mem[prog_req_in.addr[2:0]] :
                   cfg_view(prog_req_in.addr, region_bits,
                            config_write_protect);
      prog_refused_out <= prog_req_in.valid && prog_in_region &&
                          !prog_bits.code_protect;
    end
  end
  assign prog_rdata_out = prog_from_flash ? flash_rdata_in : prog_hold;

endmodule // pmbp_top

// ---- pmbp_asserts.sv ----
/* Port timing checker for pmbp_top.
   Assumes binding to every pmbp_top instance. */
module pmbp_asserts
  import pmbp_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire pmbp_req_t core_req_in,
  input wire pmbp_req_t prog_req_in,
  input wire pmbp_erase_t prog_erase_in,
  input wire logic flash_write_out,
  input wire logic core_rvalid_out,
  input wire logic core_refused_out,
  input wire logic prog_rvalid_out,
  input wire logic [7:0] prog_rdata_out,
  input wire logic prog_refused_out,
  input wire logic [PMBP_NUM_REGIONS-1:0] region_erase_out
);
  // ****
  // request answers
  // ****
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic c_go;
  logic p_go;
  // a core request is dropped while the programmer is active
  assign c_go = clk_en_in && core_req_in.valid && !prog_req_in.valid;
  assign p_go = clk_en_in && prog_req_in.valid;
  sequence s_crd; c_go && !core_req_in.write; endsequence
  sequence s_cwr; c_go && core_req_in.write; endsequence
  property p_crd; s_crd |=> core_rvalid_out; endproperty
  a_crd: assert property (p_crd)
    else $error("core read not answered");
  property p_cwr; s_cwr |=> !core_rvalid_out; endproperty
  a_cwr: assert property (p_cwr)
    else $error("core write gave read data");
  property p_ref; core_refused_out |-> $past(c_go && core_req_in.write);
  endproperty
  a_ref: assert property (p_ref)
    else $error("refusal without core write");
  property p_pass; s_cwr ##0 flash_write_out |=> !core_refused_out;
  endproperty
  a_pass: assert property (p_pass)
    else $error("written yet refused");
  property p_prd; p_go && !prog_req_in.write |=> prog_rvalid_out;
  endproperty
  a_prd: assert property (p_prd)
    else $error("programmer read not answered");
  property p_pzero;
    prog_refused_out && prog_rvalid_out |-> prog_rdata_out == 8'h00;
  endproperty
  a_pzero: assert property (p_pzero)
    else $error("blocked read leaked data");
  property p_esrc;
    region_erase_out != 3'h0 |-> prog_erase_in != PMBP_ERASE_NONE;
  endproperty
  a_esrc: assert property (p_esrc)
    else $error("erase without command");
  property p_eblk;
    clk_en_in && prog_erase_in == PMBP_ERASE_BLK0 |-> region_erase_out == 3'h2;
  endproperty
  a_eblk: assert property (p_eblk)
    else $error("block erase strobe wrong");
endmodule // pmbp_asserts
bind pmbp_top pmbp_asserts u_asserts (.*);

// ---- pmbp_flash_model.sv ----
/* Flash array model facing pmbp_top.
   Assumes 16 Kbyte array, read data one cycle after access. */
module pmbp_flash_model (
  input wire logic clk_in,
  input wire logic boot_large_in,
  input wire logic access_in,
  input wire logic write_in,
  input wire logic [21:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [2:0] erase_in,
  output logic [7:0] rdata_out
);
  // ****
  // array
  // ****
  logic [7:0] mem [0:16383];
  int r;
  initial begin
    rdata_out = 8'h00;
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  // read data stands one cycle, then toggles each idle cycle so stale data is inverted one cycle later
  always @(posedge clk_in) begin
    rdata_out <= (access_in && !write_in) ? mem[addr_in[13:0]] : ~rdata_out;
    if (access_in && write_in) mem[addr_in[13:0]] <= wdata_in;
    if (|erase_in) foreach (mem[i]) begin
      r = i <= (boot_large_in ? 32'hFFF : 32'h7FF) ? 0 : i < 32'h2000 ? 1 : 2;
      if (erase_in[r]) mem[i] <= 8'hFF;
    end
  end
endmodule // pmbp_flash_model

// ---- pmbp_top_tb.sv ----
/* Self-checking bench for pmbp_top.
   Assumes answers come one cycle after a request is taken. */
module pmbp_top_tb
  import pmbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // bench
  // ****
  localparam logic [21:0] Z = 22'h000000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic big = 1'b0;
  logic [21:0] fetch = Z;
  logic [21:0] fa, a;
  logic [7:0] frd, fwd, crd, prd, v, id0;
  logic facc, fwr, crv, cref, prv, pref, wc = 1'b1;
  logic [2:0] rer, cp = 3'h7, wp = 3'h7, rp = 3'h7;
  pmbp_req_t creq = '0, preq = '0;
  pmbp_erase_t pe = PMBP_ERASE_NONE;
  int n_fail = 0, compares = 0, seed = 76809, k;
  pmbp_top u_dut (.core_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(clk_en),
    .boot_large_in(big), .core_req_in(creq), .core_fetch_addr_in(fetch),
    .prog_req_in(preq), .prog_erase_in(pe), .flash_rdata_in(frd),
    .flash_access_out(facc), .flash_write_out(fwr), .flash_addr_out(fa),
    .flash_wdata_out(fwd), .core_rvalid_out(crv), .core_rdata_out(crd),
    .core_refused_out(cref), .prog_rvalid_out(prv), .prog_rdata_out(prd),
    .prog_refused_out(pref), .region_erase_out(rer));
  pmbp_flash_model u_mem (.clk_in(clk), .boot_large_in(big),
    .access_in(facc), .write_in(fwr), .addr_in(fa), .wdata_in(fwd),
    .erase_in(rer), .rdata_out(frd));
  always #5 clk = ~clk;
  // expected protection byte from the tracked bits
  function automatic logic [7:0] cfg_exp(input int i);
    logic [2:0] b;
    b = i < 10 ? cp : i < 12 ? wp : rp;
    return i[0] ? {1'b0, b[0], wc && i == 11, 5'h00} : {6'h00, b[2:1]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // one request, driven at the falling edge, answer seen one cycle later
  task automatic op(input logic p, w, input logic [21:0] ad,
      input logic [7:0] d, input logic [21:0] f);
    @(negedge clk);
    if (p) preq <= {1'b1, w, ad, d};
    else creq <= {1'b1, w, ad, d};
    fetch <= f;
    @(negedge clk);
    preq <= '0;
    creq <= '0;
  endtask
  task automatic crd_chk(input logic [21:0] ad, f, input logic [7:0] e);
    op(1'b0, 1'b0, ad, 8'h00, f);
    chk("core_rvalid", 8'h01, {7'h00, crv});
    chk("core_rdata", e, crd);
  endtask
  task automatic cwr_chk(input logic [21:0] ad, input logic [7:0] d,
      input logic rf);
    op(1'b0, 1'b1, ad, d, Z);
    chk("core_refused", {7'h00, rf}, {7'h00, cref});
  endtask
  task automatic prd_chk(input logic [21:0] ad, input logic [7:0] e,
      input logic rf);
    op(1'b1, 1'b0, ad, 8'h00, Z);
    chk("prog_rvalid", 8'h01, {7'h00, prv});
    chk("prog_rdata", e, prd);
    chk("prog_refused", {7'h00, rf}, {7'h00, pref});
  endtask
  task automatic cfg_all();
    for (int i = 8; i < 14; i++) crd_chk(PMBP_CFG_START + 22'(i), Z, cfg_exp(i));
  endtask
  task automatic erase(input pmbp_erase_t e);
    @(negedge clk);
    pe <= e;
    @(negedge clk);
    pe <= PMBP_ERASE_NONE;
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n <= 1'b1;
    cfg_all();
    crd_chk(PMBP_DEVID_HI, Z, PMBP_DEVID_HI_VAL);
    for (int i = 0; i < 8; i++) begin
      k = $random(seed);
      op(1'b0, 1'b1, PMBP_ID_START + 22'(i), k[7:0], Z);
      prd_chk(PMBP_ID_START + 22'(i), k[7:0], 1'b0);
    end
    id0 = k[7:0];
    repeat (24) begin
      k = $random(seed);
      a = {8'h00, k[13:0]};
      if (a[13:11] == 3'b001) a[12] = 1'b1;
      cwr_chk(a, k[21:14], 1'b0);
      crd_chk(a, a, k[21:14]);
    end
    op(1'b1, 1'b1, PMBP_BLOCK_WRITE_PROTECT_LOW, 8'hFE, Z);
    wp[1] = 1'b0;
    op(1'b1, 1'b1, PMBP_BLOCK_WRITE_PROTECT_LOW, 8'hFF, Z);
    cfg_all();
    v = u_mem.mem[14'h1234];
    cwr_chk(22'h001234, 8'h5A, 1'b1);
    crd_chk(22'h001234, 22'h001000, v);
    cwr_chk(22'h002345, 8'h3C, 1'b0);
    op(1'b0, 1'b1, PMBP_BLOCK_TABLE_READ_PROTECT_LOW, 8'hFE, Z);
    rp[1] = 1'b0;
    cfg_all();
    crd_chk(22'h001234, 22'h000100, 8'h00);
    crd_chk(22'h001234, 22'h001100, v);
    op(1'b1, 1'b1, PMBP_BLOCK_CODE_PROTECT_LOW, 8'hFE, Z);
    cp[1] = 1'b0;
    prd_chk(22'h001234, 8'h00, 1'b1);
    crd_chk(22'h001234, 22'h001100, v);
    prd_chk(22'h002345, 8'h3C, 1'b0);
    // core write beside a programmer read is dropped, not refused
    @(negedge clk);
    creq <= {1'b1, 1'b1, 22'h002345, 8'h77};
    preq <= {1'b1, 1'b0, 22'h002345, 8'h00};
    @(negedge clk);
    creq <= '0;
    preq <= '0;
    chk("core_refused", 8'h00, {7'h00, cref});
    chk("prog_rdata", 8'h3C, prd);
    crd_chk(22'h002345, 22'h002345, 8'h3C);
    prd_chk(PMBP_ID_END, id0, 1'b0);
    op(1'b0, 1'b1, PMBP_BOOT_CONFIG_WRITE_PROTECT_HIGH, 8'h00, Z);
    wp[0] = 1'b0;
    cfg_all();
    big = 1'b1;
    cwr_chk(22'h000FFF, 8'h11, 1'b1);
    big = 1'b0;
    cwr_chk(22'h0007FF, 8'h11, 1'b1);
    op(1'b1, 1'b1, PMBP_BOOT_CONFIG_WRITE_PROTECT_HIGH, 8'h00, Z);
    wc = 1'b0;
    cfg_all();
    cwr_chk(PMBP_BLOCK_TABLE_READ_PROTECT_LOW, 8'h00, 1'b1);
    erase(PMBP_ERASE_BLK0);
    cp[1] = 1'b1;
    wp[1] = 1'b1;
    rp[1] = 1'b1;
    cfg_all();
    erase(PMBP_ERASE_CHIP);
    {cp, wp, rp, wc} = 10'h3FF;
    cfg_all();
    report_and_stop();
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
endmodule // pmbp_top_tb
